// ### src/fsp_pkg.sv
// Functional notes
// - busy high during program, erase, non-volatile status write
// - while busy, discard all but status reads
// - busy clears when the operation finishes
// - write enable sets the write-enable latch
// - latch cleared at power-up, disable, program, erase
// - guard bits at status_one[4:2], default zero
// - reject program/erase into the protected region
// - guard_from_low_end at status_one[5], default zero
// - guard_from_low_end write needs lock bits and latch
// - guard_granularity_small at status_one[6], default zero
// - guard_invert at status_two[6] inverts the region
// - lock bits at status_two[0], status_one[7]
// - lock 00: pin ignored, write needs latch
// - lock 01 and pin low: status locked
// - lock 01 and pin high: writable after enable
// - lock 10: locked until power cycle
// - lock 11: locked permanently; here rst_i clears it along with every other status bit
// - lock 10 returns to 00 on reset
// - busy, latch, suspend never written by software
// - enable kind picks non-volatile or volatile copies
package fsp_pkg;

   // ------------------------------------------------------------
   // instruction codes
   // ------------------------------------------------------------
   localparam logic [7:0] OPC_WREN = 8'h06;
   localparam logic [7:0] OPC_WREN_VOL = 8'h50;
   localparam logic [7:0] OPC_WRDI = 8'h04;
   localparam logic [7:0] OPC_WRSR = 8'h01;
   localparam logic [7:0] OPC_RDSR1 = 8'h05;
   localparam logic [7:0] OPC_RDSR2 = 8'h35;
   localparam logic [7:0] OPC_PROG = 8'h02;
   localparam logic [7:0] OPC_SE = 8'h20;
   localparam logic [7:0] OPC_BE32 = 8'h52;
   localparam logic [7:0] OPC_BE64 = 8'hd8;
   localparam logic [7:0] OPC_CE_A = 8'hc7;
   localparam logic [7:0] OPC_CE_B = 8'h60;
   localparam logic [7:0] OPC_RST_EN = 8'h66;
   localparam logic [7:0] OPC_RST = 8'h99;

   // ------------------------------------------------------------
   // status field positions and masks
   // ------------------------------------------------------------
   localparam int S1_BUSY = 0;
   localparam int S1_WEL = 1;
   localparam int S1_BP_LSB = 2;
   localparam int S1_TB = 5;
   localparam int S1_SEC = 6;
   localparam int S1_LOCK_LO = 7;
   localparam int S2_LOCK_HI = 0;
   localparam int S2_INV = 6;
   localparam int S2_SUS = 7;
   localparam logic [7:0] S1_WMASK = 8'hfc;
   localparam logic [7:0] S2_WMASK = 8'h41;
   localparam logic [7:0] S1_RESET = 8'h00;
   localparam logic [7:0] S2_RESET = 8'h00;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_NS = 10;
   localparam int SRW_NS = 200;
   localparam int SRW_CYCLES = (SRW_NS + CLK_NS - 1) / CLK_NS;
   localparam int SRW_CW = 16;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      FSP_OP_PROG = 2'b00,
      FSP_OP_SECTOR = 2'b01,
      FSP_OP_BLOCK = 2'b10,
      FSP_OP_CHIP = 2'b11
   } fsp_op_e;

   typedef enum logic [1:0] {
      FSP_ST_IDLE = 2'b00,
      FSP_ST_CHECK = 2'b01,
      FSP_ST_OP = 2'b10,
      FSP_ST_SRW = 2'b11
   } fsp_state_e;

endpackage

// ### src/fsp_link_if.sv
interface fsp_link_if;
   logic [7:0] byte_data;
   logic byte_tog;
   logic mid_byte;
   logic [7:0] status_one;
   logic [7:0] status_two;

   modport front (
      output byte_data,
      output byte_tog,
      output mid_byte,
      input status_one,
      input status_two
   );

   modport core (
      input byte_data,
      input byte_tog,
      input mid_byte,
      output status_one,
      output status_two
   );
endinterface

// ### src/fsp_spi_front.sv
module fsp_spi_front (
   input wire logic rst_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic miso_oe_o,
   fsp_link_if.front lnk
);

   logic [2:0] bit_cnt_r;
   logic [6:0] shift_r;
   logic first_r;
   logic [7:0] op_r;
   logic [7:0] s1_m_r;
   logic [7:0] s1_r;
   logic [7:0] s2_m_r;
   logic [7:0] s2_r;
   logic [7:0] out_r;
   logic [7:0] byte_r;
   logic tog_r;
   logic mid_r;

   wire byte_end = (bit_cnt_r == 3'h7);
   wire [7:0] rx_byte = {shift_r, mosi_i};
   wire is_rd1 = (op_r == fsp_pkg::OPC_RDSR1);
   wire is_rd2 = (op_r == fsp_pkg::OPC_RDSR2);

   // ------------------------------------------------------------
   // frame state, cleared by chip select since the clock stops
   // ------------------------------------------------------------
   always_ff @(posedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         bit_cnt_r <= 3'h0;
         shift_r <= 7'h00;
         first_r <= 1'b0;
         op_r <= 8'h00;
         s1_m_r <= 8'h00;
         s1_r <= 8'h00;
         s2_m_r <= 8'h00;
         s2_r <= 8'h00;
      end else begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         shift_r <= rx_byte[6:0];
         s1_m_r <= lnk.status_one;
         s1_r <= s1_m_r;
         s2_m_r <= lnk.status_two;
         s2_r <= s2_m_r;
         if (byte_end && !first_r) begin
            op_r <= rx_byte;
            first_r <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // byte hand-off; survives the frame end so a cut byte is seen
   // ------------------------------------------------------------
   always_ff @(posedge sck_i or posedge rst_i) begin
      if (rst_i) begin
         byte_r <= 8'h00;
         tog_r <= 1'b0;
         mid_r <= 1'b0;
      end else if (!cs_n_i) begin
         mid_r <= !byte_end;
         if (byte_end) begin
            byte_r <= rx_byte;
            tog_r <= !tog_r;
         end
      end
   end

   // ------------------------------------------------------------
   // status read-out, repeated every byte
   // ------------------------------------------------------------
   always_ff @(negedge sck_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         out_r <= 8'h00;
      end else if (first_r && bit_cnt_r == 3'h0) begin
         out_r <= is_rd1 ? s1_r : s2_r;
      end else begin
         out_r <= {out_r[6:0], 1'b0};
      end
   end

   assign lnk.byte_data = byte_r;
   assign lnk.byte_tog = tog_r;
   assign lnk.mid_byte = mid_r;
   assign miso_o = out_r[7];
   assign miso_oe_o = !cs_n_i && first_r && (is_rd1 || is_rd2);

endmodule

// ### src/fsp_status_regs.sv
module fsp_status_regs #(
   parameter int SRW_CYCLES = fsp_pkg::SRW_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic mosi_i,
   output logic miso_o,
   output logic miso_oe_o,
   input wire logic wp_n_i,
   input wire logic op_done_i,
   input wire logic suspend_i,
   input wire logic region_hit_i,
   output logic op_start_o,
   output fsp_pkg::fsp_op_e op_kind_o,
   output logic [23:0] op_addr_o,
   output logic [2:0] guard_bp_o,
   output logic guard_from_low_end_o,
   output logic guard_granularity_small_o,
   output logic guard_invert_o,
   output logic busy_o,
   output logic write_enable_latch_o
);

   localparam logic [fsp_pkg::SRW_CW-1:0] SRW_LOAD =
      fsp_pkg::SRW_CW'(SRW_CYCLES - 1);

   // ------------------------------------------------------------
   // serial front end on the link clock
   // ------------------------------------------------------------
   fsp_link_if lnk ();

   fsp_spi_front u_front (
      .rst_i(rst_i),
      .sck_i(sck_i),
      .cs_n_i(cs_n_i),
      .mosi_i(mosi_i),
      .miso_o(miso_o),
      .miso_oe_o(miso_oe_o),
      .lnk(lnk.front)
   );

   // ------------------------------------------------------------
   // crossings into the system clock
   // ------------------------------------------------------------
   logic cs_m_r;
   logic cs_s_r;
   logic cs_d_r;
   logic tog_m_r;
   logic tog_s_r;
   logic tog_d_r;
   logic mid_m_r;
   logic mid_s_r;
   logic wp_m_r;
   logic wp_s_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cs_m_r <= 1'b1;
         cs_s_r <= 1'b1;
         cs_d_r <= 1'b1;
         tog_m_r <= 1'b0;
         tog_s_r <= 1'b0;
         tog_d_r <= 1'b0;
         mid_m_r <= 1'b0;
         mid_s_r <= 1'b0;
         wp_m_r <= 1'b0;
         wp_s_r <= 1'b0;
      end else begin
         cs_m_r <= cs_n_i;
         cs_s_r <= cs_m_r;
         cs_d_r <= cs_s_r;
         tog_m_r <= lnk.byte_tog;
         tog_s_r <= tog_m_r;
         tog_d_r <= tog_s_r;
         mid_m_r <= lnk.mid_byte;
         mid_s_r <= mid_m_r;
         wp_m_r <= wp_n_i;
         wp_s_r <= wp_m_r;
      end
   end

   wire byte_ev = tog_s_r ^ tog_d_r;
   wire frame_end = cs_s_r && !cs_d_r;

   // ------------------------------------------------------------
   // instruction capture
   // ------------------------------------------------------------
   // the front end holds byte_data for a whole byte time after the
   // toggle, far longer than the three-cycle sync, so it is read as
   // a quasi-static word here
   logic [2:0] byte_cnt_r;
   logic [7:0] opcode_r;
   logic [23:0] arg_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         byte_cnt_r <= 3'h0;
         opcode_r <= 8'h00;
         arg_r <= 24'h000000;
      end else if (frame_end) begin
         byte_cnt_r <= 3'h0;
      end else if (byte_ev) begin
         if (byte_cnt_r == 3'h0) begin
            opcode_r <= lnk.byte_data;
         end else if (byte_cnt_r < 3'h4) begin
            arg_r <= {arg_r[15:0], lnk.byte_data};
         end
         if (byte_cnt_r != 3'h7) begin
            byte_cnt_r <= byte_cnt_r + 3'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   fsp_pkg::fsp_state_e state_r;
   fsp_pkg::fsp_state_e state_nxt;
   logic [fsp_pkg::SRW_CW-1:0] srw_cnt_r;
   logic wel_r;
   logic vol_wel_r;
   logic rst_en_r;
   logic [7:0] nv1_r;
   logic [7:0] nv2_r;
   logic [7:0] vol1_r;
   logic [7:0] vol2_r;
   logic op_start_r;
   fsp_pkg::fsp_op_e op_kind_r;
   logic [23:0] op_addr_r;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire busy = (state_r != fsp_pkg::FSP_ST_IDLE);
   // a cut byte or a busy device voids the instruction
   wire exec = frame_end && !mid_s_r && !busy;
   wire one_b = (byte_cnt_r == 3'h1);
   wire four_b = (byte_cnt_r == 3'h4);
   wire do_wren = exec && one_b && opcode_r == fsp_pkg::OPC_WREN;
   wire do_wren_vol = exec && one_b &&
      opcode_r == fsp_pkg::OPC_WREN_VOL;
   wire do_wrdi = exec && one_b && opcode_r == fsp_pkg::OPC_WRDI;
   wire do_rst_en = exec && one_b && opcode_r == fsp_pkg::OPC_RST_EN;
   wire do_rst = exec && one_b && opcode_r == fsp_pkg::OPC_RST &&
      rst_en_r;
   wire wrsr_len = (byte_cnt_r == 3'h2) || (byte_cnt_r == 3'h3);
   wire do_wrsr = exec && wrsr_len && opcode_r == fsp_pkg::OPC_WRSR;
   wire wrsr_two = (byte_cnt_r == 3'h3);
   wire is_prog = (opcode_r == fsp_pkg::OPC_PROG) &&
      (byte_cnt_r > 3'h4);
   wire is_se = four_b && (opcode_r == fsp_pkg::OPC_SE);
   wire is_be = four_b && (opcode_r == fsp_pkg::OPC_BE32 ||
      opcode_r == fsp_pkg::OPC_BE64);
   wire is_ce = one_b && (opcode_r == fsp_pkg::OPC_CE_A ||
      opcode_r == fsp_pkg::OPC_CE_B);
   wire do_array = exec && wel_r && (is_prog || is_se || is_be || is_ce);
   wire any_write = exec && (is_prog || is_se || is_be || is_ce ||
      (opcode_r == fsp_pkg::OPC_WRSR && wrsr_len));

   wire [1:0] lock = {vol2_r[fsp_pkg::S2_LOCK_HI],
      vol1_r[fsp_pkg::S1_LOCK_LO]};
   // 00 ignores the pin, 01 follows it, 10 and 11 refuse outright
   wire status_open = (lock == 2'b00) ||
      (lock == 2'b01 && wp_s_r);
   wire nv_write = do_wrsr && wel_r && status_open;
   wire vol_write = do_wrsr && !wel_r && vol_wel_r && status_open;

   // new values only touch writable bits; busy, latch and
   // suspend are never taken from the host
   wire [7:0] wr_s1 = wrsr_two ? arg_r[15:8] : arg_r[7:0];
   wire [7:0] new1 = (wr_s1 & fsp_pkg::S1_WMASK) |
      (vol1_r & ~fsp_pkg::S1_WMASK);
   wire [7:0] new2 = wrsr_two ?
      ((arg_r[7:0] & fsp_pkg::S2_WMASK) |
      (vol2_r & ~fsp_pkg::S2_WMASK)) : vol2_r;

   wire lockdown_nv = nv2_r[fsp_pkg::S2_LOCK_HI] &&
      !nv1_r[fsp_pkg::S1_LOCK_LO];

   wire guard_inv = vol2_r[fsp_pkg::S2_INV];
   wire [2:0] guard_bp = vol1_r[fsp_pkg::S1_BP_LSB +: 3];
   // the outside table answers for op_addr_o; invert flips it
   wire addr_guarded = region_hit_i ^ guard_inv;
   // chip erase needs an empty region: no guard bits and no invert
   wire chip_guarded = (guard_bp != 3'h0) || guard_inv;
   wire reject = (op_kind_r == fsp_pkg::FSP_OP_CHIP) ?
      chip_guarded : addr_guarded;

   wire fsp_pkg::fsp_op_e kind_sel =
      is_prog ? fsp_pkg::FSP_OP_PROG :
      is_se ? fsp_pkg::FSP_OP_SECTOR :
      is_be ? fsp_pkg::FSP_OP_BLOCK : fsp_pkg::FSP_OP_CHIP;

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         fsp_pkg::FSP_ST_IDLE: begin
            if (do_array) begin
               state_nxt = fsp_pkg::FSP_ST_CHECK;
            end else if (nv_write) begin
               state_nxt = fsp_pkg::FSP_ST_SRW;
            end
         end
         fsp_pkg::FSP_ST_CHECK: begin
            state_nxt = reject ? fsp_pkg::FSP_ST_IDLE :
               fsp_pkg::FSP_ST_OP;
         end
         fsp_pkg::FSP_ST_OP: begin
            if (op_done_i) begin
               state_nxt = fsp_pkg::FSP_ST_IDLE;
            end
         end
         fsp_pkg::FSP_ST_SRW: begin
            if (srw_cnt_r == '0) begin
               state_nxt = fsp_pkg::FSP_ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= fsp_pkg::FSP_ST_IDLE;
         srw_cnt_r <= '0;
      end else begin
         state_r <= state_nxt;
         if (state_r == fsp_pkg::FSP_ST_IDLE) begin
            srw_cnt_r <= SRW_LOAD;
         end else if (srw_cnt_r != '0) begin
            srw_cnt_r <= srw_cnt_r - 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // array operation launch
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op_start_r <= 1'b0;
         op_kind_r <= fsp_pkg::FSP_OP_PROG;
         op_addr_r <= 24'h000000;
      end else begin
         op_start_r <= (state_r == fsp_pkg::FSP_ST_CHECK) && !reject;
         if (do_array) begin
            op_kind_r <= kind_sel;
            op_addr_r <= is_ce ? 24'h000000 : arg_r;
         end
      end
   end

   // ------------------------------------------------------------
   // write-enable latches
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wel_r <= 1'b0;
         vol_wel_r <= 1'b0;
         rst_en_r <= 1'b0;
      end else begin
         if (do_wren) begin
            wel_r <= 1'b1;
         end else if (do_wrdi || any_write || do_rst) begin
            wel_r <= 1'b0;
         end
         if (do_wren_vol) begin
            vol_wel_r <= 1'b1;
         end else if (do_wren || do_wrdi || any_write || do_rst) begin
            vol_wel_r <= 1'b0;
         end
         if (exec) begin
            rst_en_r <= do_rst_en;
         end
      end
   end

   // ------------------------------------------------------------
   // status copies
   // ------------------------------------------------------------
   // the volatile copy is what steers protection; a non-volatile
   // write lands in both so they stay in step
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         nv1_r <= fsp_pkg::S1_RESET;
         nv2_r <= fsp_pkg::S2_RESET;
         vol1_r <= fsp_pkg::S1_RESET;
         vol2_r <= fsp_pkg::S2_RESET;
      end else if (nv_write) begin
         nv1_r <= new1;
         nv2_r <= new2;
         vol1_r <= new1;
         vol2_r <= new2;
      end else if (vol_write) begin
         vol1_r <= new1;
         vol2_r <= new2;
      end else if (do_rst) begin
         vol1_r <= nv1_r;
         vol2_r <= nv2_r;
         if (lockdown_nv) begin
            nv2_r[fsp_pkg::S2_LOCK_HI] <= 1'b0;
            vol2_r[fsp_pkg::S2_LOCK_HI] <= 1'b0;
            vol1_r[fsp_pkg::S1_LOCK_LO] <= 1'b0;
         end
      end
      // a refused write falls through and keeps every bit
   end

   // ------------------------------------------------------------
   // outputs and read-back
   // ------------------------------------------------------------
   assign lnk.status_one = {vol1_r[7:2], wel_r, busy};
   assign lnk.status_two = {suspend_i, vol2_r[6:0]};
   assign op_start_o = op_start_r;
   assign op_kind_o = op_kind_r;
   assign op_addr_o = op_addr_r;
   assign guard_bp_o = guard_bp;
   assign guard_from_low_end_o = vol1_r[fsp_pkg::S1_TB];
   assign guard_granularity_small_o = vol1_r[fsp_pkg::S1_SEC];
   assign guard_invert_o = guard_inv;
   assign busy_o = busy;
   assign write_enable_latch_o = wel_r;

endmodule

// ### tb/fsp_host_model.sv
module fsp_host_model (
   input wire logic miso_i,
   output logic sck_o,
   output logic cs_n_o,
   output logic mosi_o
);
   timeunit 1ns;
   timeprecision 10ps;
   logic [7:0] rd_byte;
   event rd_ev;
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
      rd_byte = 8'h00;
   end
   // ------------------------------------------------------------
   // one frame: n bytes from the top of d, then a byte read back when rd is set
   // ------------------------------------------------------------
   // gap first, so the caller can watch effects as cs rises
   task automatic xfer(input int n, input logic [39:0] d, input bit rd);
      int nb;
      nb = 8 * n + (rd ? 8 : 0);
      #80;
      cs_n_o = 1'b0;
      for (int i = 0; i < nb; i++) begin
         mosi_o = (i < 8 * n) ? d[39 - i] : ~mosi_o;
         #3.75;
         sck_o = 1'b1;
         rd_byte = {rd_byte[6:0], miso_i};
         #7.5;
         sck_o = 1'b0;
         #3.75;
      end
      cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
      if (rd) begin
         -> rd_ev;
      end
   endtask
endmodule

// ### tb/fsp_status_regs_properties.sv
module fsp_status_regs_properties #(
   parameter int SRW_CYCLES = fsp_pkg::SRW_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic op_done_i,
   input wire logic op_start_o,
   input wire logic busy_o,
   input wire logic write_enable_latch_o,
   input wire logic [2:0] guard_bp_o,
   input wire logic guard_from_low_end_o,
   input wire logic guard_granularity_small_o,
   input wire logic guard_invert_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // ------------------------------------------------------------
   // helpers: inside an engine run, length of the busy run
   // ------------------------------------------------------------
   logic in_op_r;
   logic [15:0] run_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         in_op_r <= 1'b0;
         run_r <= 16'h0;
      end else begin
         in_op_r <= op_start_o | (in_op_r & busy_o);
         run_r <= busy_o ? run_r + 16'h1 : 16'h0;
      end
   end
   a_start_busy: assert property (op_start_o |-> busy_o)
      else $error("op start without busy");
   a_start_pulse: assert property (op_start_o |=> !op_start_o)
      else $error("op start longer than one cycle");
   a_start_checked: assert property (op_start_o |-> $past(busy_o))
      else $error("op start without check cycle");
   a_done_frees: assert property (in_op_r && op_done_i |=> !busy_o)
      else $error("busy kept after engine done");
   a_op_holds: assert property (in_op_r && busy_o && !op_done_i |=> busy_o)
      else $error("busy dropped before engine done");
   a_start_wel: assert property (op_start_o |-> !write_enable_latch_o)
      else $error("latch still set at op start");
   a_guard_frozen: assert property (busy_o && $past(busy_o) |->
      $stable({guard_bp_o, guard_from_low_end_o, guard_granularity_small_o,
      guard_invert_o})) else $error("guard bits changed while busy");
   a_busy_wel: assert property (busy_o && $past(busy_o) |->
      !$rose(write_enable_latch_o)) else $error("latch set while busy");
   a_srw_bound: assert property (!in_op_r && !op_start_o |->
      run_r <= SRW_CYCLES + 1) else $error("status write busy too long");
   a_reset_clear: assert property (disable iff (1'b0) rst_i |=>
      !busy_o && !write_enable_latch_o && guard_bp_o == 3'h0)
      else $error("state not cleared by reset");
endmodule

// ### tb/tb_flash_status_protect_regs.sv
module tb_flash_status_protect_regs;
   timeunit 1ns;
   timeprecision 10ps;
   localparam int SRW = 4;
   logic clk_i, rst_i, sck, cs_n, mosi, miso, miso_oe, miso_w;
   logic wp_n, op_done, susp, hit, op_start, busy, write_enable_latch, lo_b, sm_b, inv_b;
   fsp_pkg::fsp_op_e op_kind, exp_kind, knd[4];
   logic [23:0] op_addr, exp_addr;
   logic [2:0] bp;
   logic [7:0] v, exp_q[$], opc[4];
   int errors = 0, tests_run = 0, starts = 0, n, len[4];
   // released line shows a changing pattern, never the last bit
   assign miso_w = miso_oe ? miso : ~clk_i;
   fsp_status_regs #(.SRW_CYCLES(SRW)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .sck_i(sck), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
      .miso_oe_o(miso_oe), .wp_n_i(wp_n), .op_done_i(op_done),
      .suspend_i(susp), .region_hit_i(hit), .op_start_o(op_start),
      .op_kind_o(op_kind), .op_addr_o(op_addr), .guard_bp_o(bp),
      .guard_from_low_end_o(lo_b), .guard_granularity_small_o(sm_b),
      .guard_invert_o(inv_b), .busy_o(busy), .write_enable_latch_o(write_enable_latch));
   fsp_host_model host (.miso_i(miso_w), .sck_o(sck), .cs_n_o(cs_n),
      .mosi_o(mosi));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic rdst(logic [7:0] op, logic [7:0] e);
      exp_q.push_back(e);
      host.xfer(1, {op, 32'h0}, 1'b1);
   endtask
   task automatic cmd(int k, logic [39:0] d);
      host.xfer(k, d, 1'b0);
   endtask
   task automatic op1(logic [7:0] op);
      cmd(1, {op, 32'h0});
   endtask
   task automatic wsr(logic [7:0] a, logic [7:0] b);
      cmd(3, {fsp_pkg::OPC_WRSR, a, b, 16'h0});
   endtask
   task automatic cnt_busy(output int c);
      c = 0;
      for (int i = 0; i < 20 && busy !== 1'b1; i++) @(negedge clk_i);
      while (busy === 1'b1 && c < 1000) begin
         c++;
         @(negedge clk_i);
      end
   endtask
   task automatic set_wp(logic x);
      @(posedge clk_i);
      wp_n <= x;
      repeat (5) @(posedge clk_i);
   endtask
   task automatic tdone(string s);
      $display("test %0s done", s);
   endtask
   always @(host.rd_ev) begin
      if (exp_q.size() == 0) chk("read note", 24'h1, 24'h0);
      else chk("status read", {16'h0, exp_q.pop_front()}, {16'h0, host.rd_byte});
   end
   // engine stand-in: checks the launch, finishes after a while
   initial begin
      forever begin
         @(posedge clk_i);
         if (op_start === 1'b1) begin
            starts++;
            chk("op kind", {22'h0, exp_kind}, {22'h0, op_kind});
            chk("op addr", exp_addr, op_addr);
            repeat (150) @(posedge clk_i);
            op_done <= 1'b1;
            @(posedge clk_i);
            op_done <= 1'b0;
         end
      end
   end
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      #200us;
      errors++;
      close_out();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      wp_n = 1'b1;
      op_done = 1'b0;
      susp = 1'b0;
      hit = 1'b0;
      exp_kind = fsp_pkg::FSP_OP_PROG;
      exp_addr = 24'h0;
      opc = '{fsp_pkg::OPC_PROG, fsp_pkg::OPC_SE, fsp_pkg::OPC_BE64,
         fsp_pkg::OPC_CE_A};
      knd = '{fsp_pkg::FSP_OP_PROG, fsp_pkg::FSP_OP_SECTOR,
         fsp_pkg::FSP_OP_BLOCK, fsp_pkg::FSP_OP_CHIP};
      len = '{5, 4, 4, 1};
      v = 8'($urandom(3));
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      susp <= 1'($urandom);
      @(posedge clk_i);
      rdst(fsp_pkg::OPC_RDSR1, 8'h00);
      rdst(fsp_pkg::OPC_RDSR2, {susp, 7'h0});
      chk("guards", 24'h0, {18'h0, bp, lo_b, sm_b, inv_b});
      tdone("reset");
      op1(fsp_pkg::OPC_WREN);
      rdst(fsp_pkg::OPC_RDSR1, 8'h02);
      op1(fsp_pkg::OPC_WRDI);
      rdst(fsp_pkg::OPC_RDSR1, 8'h00);
      tdone("latch");
      v = 8'($urandom) & 8'h7c;
      op1(fsp_pkg::OPC_WREN);
      wsr(v | 8'h03, 8'h40);
      cnt_busy(n);
      chk("busy cycles", 24'(SRW), 24'(n));
      rdst(fsp_pkg::OPC_RDSR1, v);
      rdst(fsp_pkg::OPC_RDSR2, {susp, 7'h40});
      chk("guards", {18'h0, v[4:2], v[5], v[6], 1'b1},
         {18'h0, bp, lo_b, sm_b, inv_b});
      wsr(8'h00, 8'h00);
      rdst(fsp_pkg::OPC_RDSR1, v);
      tdone("write");
      op1(fsp_pkg::OPC_WREN);
      wsr(v | 8'h80, 8'h00);
      set_wp(1'b0);
      op1(fsp_pkg::OPC_WREN);
      rdst(fsp_pkg::OPC_RDSR1, v | 8'h82);
      wsr(8'h00, 8'h00);
      rdst(fsp_pkg::OPC_RDSR1, v | 8'h80);
      set_wp(1'b1);
      op1(fsp_pkg::OPC_WREN);
      wsr(8'h00, 8'h01);
      rdst(fsp_pkg::OPC_RDSR2, {susp, 7'h01});
      op1(fsp_pkg::OPC_WREN);
      wsr(8'h1c, 8'h00);
      rdst(fsp_pkg::OPC_RDSR1, 8'h00);
      op1(fsp_pkg::OPC_RST_EN);
      op1(fsp_pkg::OPC_RST);
      rdst(fsp_pkg::OPC_RDSR2, {susp, 7'h00});
      op1(fsp_pkg::OPC_WREN);
      wsr(8'h80, 8'h01);
      op1(fsp_pkg::OPC_WREN);
      wsr(8'h1c, 8'h01);
      rdst(fsp_pkg::OPC_RDSR1, 8'h80);
      tdone("locks");
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      op1(fsp_pkg::OPC_WREN_VOL);
      cmd(2, {fsp_pkg::OPC_WRSR, 8'h0c, 24'h0});
      cnt_busy(n);
      chk("busy cycles", 24'h0, 24'(n));
      rdst(fsp_pkg::OPC_RDSR1, 8'h0c);
      op1(fsp_pkg::OPC_RST_EN);
      op1(fsp_pkg::OPC_RST);
      rdst(fsp_pkg::OPC_RDSR1, 8'h00);
      tdone("volatile");
      for (int i = 0; i < 5; i++) begin
         exp_kind = knd[i % 4];
         exp_addr = (i == 3) ? 24'h0 : 24'($urandom);
         hit <= (i == 4);
         op1(fsp_pkg::OPC_WREN);
         cmd(len[i % 4], {opc[i % 4], exp_addr, 8'($urandom)});
         if (i == 0) begin
            rdst(fsp_pkg::OPC_RDSR1, 8'h01);
            op1(fsp_pkg::OPC_WREN);
         end
         cnt_busy(n);
         rdst(fsp_pkg::OPC_RDSR1, 8'h00);
      end
      chk("op starts", 24'h4, 24'(starts));
      tdone("engine");
      close_out();
   end
endmodule
bind fsp_status_regs fsp_status_regs_properties #(.SRW_CYCLES(SRW_CYCLES))
   u_props (.clk_i, .rst_i, .op_done_i, .op_start_o, .busy_o,
   .write_enable_latch_o, .guard_bp_o, .guard_from_low_end_o,
   .guard_granularity_small_o, .guard_invert_o);
